// File: ifi_format_inquiry.sv
// Purpose: Inquiry and status registers of the user-defined image mode
// Assumes: Settings come from same-clock logic; serial bus core does
//          the host access as single reads and writes by byte offset
// Notes:   All fields are read only; host writes are acknowledged only
//          Packet size error holds until a clean count clears it
`timescale 1ns/100ps
module ifi_format_inquiry (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    input  wire logic [2:0]  iso_speed,
    input  wire logic [15:0] area_of_interest_left,
    input  wire logic [15:0] area_of_interest_top,
    input  wire logic [15:0] area_of_interest_width,
    input  wire logic [15:0] area_of_interest_height,
    input  wire logic [7:0]  color_coding,
    input  wire logic [15:0] bytes_per_packet,
    input  wire logic        bytes_per_packet_wr,
    input  wire logic [31:0] feature_bytes,
    input  wire logic [31:0] frame_period_ticks,
    input  wire logic        capture_req,
    output logic             capture_start,
    output logic             capture_refused,
    output logic             format_error,
    output logic             packet_error
);
    import ifi_pkg::*;

    // Settings snapshot used to detect any change
    logic [127:0] cfg_now;
    logic [127:0] cfg_reg, cfg_next;
    logic [31:0]  per_reg, per_next;
    logic         cfg_changed;
    logic         per_changed;

    // Derived format values
    logic [1:0]   pix_bytes;
    logic [7:0]   depth_comb;
    logic         coding_ok;
    logic         err_fmt_comb;
    logic         pkt_static_bad;
    logic [31:0]  frame_bytes;
    logic [16:0]  right_edge;
    logic [16:0]  bottom_edge;

    // Computation sequencer
    ifi_state_t   st_reg, st_next;
    logic         div_start;
    logic         div_done;
    logic [31:0]  div_quot;
    logic [31:0]  pkt_reg, pkt_next;
    logic         err_fmt_reg, err_fmt_next;
    logic         err_pkt_reg, err_pkt_next;
    logic         pend_reg, pend_next;
    logic [7:0]   depth_reg, depth_next;
    logic [1:0]   filt_reg, filt_next;
    logic [31:0]  period_float;

    // Bus answer and capture gate
    logic [31:0]  rdata_reg, rdata_next;
    logic         ack_reg, ack_next;
    logic         cap_reg, cap_next;
    logic         refuse_reg, refuse_next;
    logic [31:0]  rd_word;
    logic         unused_wdata;

    // Feature bytes sit whole in the snapshot: a change in any byte restarts the count
    assign cfg_now = {5'h00, iso_speed, area_of_interest_left,
                      area_of_interest_top, area_of_interest_width,
                      area_of_interest_height, color_coding,
                      bytes_per_packet, feature_bytes};
    assign cfg_changed = (cfg_now != cfg_reg) ||
                         bytes_per_packet_wr;
    // A pending recompute also reloads the period float after reset
    assign per_changed = (frame_period_ticks != per_reg) || (st_reg == ST_IDLE
                         && pend_reg);
    assign unused_wdata = ^reg_wdata;

    always_comb begin
        cfg_next = cfg_now;
        per_next = frame_period_ticks;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg_reg <= 128'h0;
            per_reg <= RESET_ZERO;
        end else begin
            cfg_reg <= cfg_next;
            per_reg <= per_next;
        end
    end

    // Pixel size and depth from the colour coding
    always_comb begin
        pix_bytes  = 2'h1;
        depth_comb = DEPTH_8;
        coding_ok  = 1'b1;
        case (color_coding)
            CC_MONO8: begin
                pix_bytes  = 2'h1;
                depth_comb = DEPTH_8;
            end
            CC_RAW8: begin
                pix_bytes  = 2'h1;
                depth_comb = DEPTH_8;
            end
            CC_YUV422: begin
                pix_bytes  = 2'h2;
                depth_comb = DEPTH_16;
            end
            default: begin
                coding_ok = 1'b0;
            end
        endcase
    end

    assign right_edge  = {1'b0, area_of_interest_left} + {1'b0, area_of_interest_width};
    assign bottom_edge = {1'b0, area_of_interest_top} + {1'b0, area_of_interest_height};

    // Combined speed, position, size and coding check
    assign err_fmt_comb = !coding_ok || (iso_speed < ISO_SPEED_MIN) ||
                          (area_of_interest_width == 16'h0000) ||
                          (area_of_interest_height == 16'h0000) ||
                          (right_edge > {1'b0, SENSOR_WIDTH}) ||
                          (bottom_edge > {1'b0, SENSOR_HEIGHT}) ||
                          area_of_interest_left[0] ||
                          area_of_interest_top[0];

    assign pkt_static_bad = (bytes_per_packet == 16'h0000) ||
                            (bytes_per_packet > PKT_MAX_BYTES) ||
                            ((bytes_per_packet & (PKT_UNIT - 16'h0001)) != 16'h0000);

    // Image bytes padded to a quadlet plus appended feature data
    always_comb begin
        logic [31:0] raw;
        raw = area_of_interest_width * area_of_interest_height;
        raw = (pix_bytes == 2'h2) ? {raw[30:0], 1'b0} : raw;
        frame_bytes = ((raw + 32'h00000003) & 32'hFFFFFFFC) + feature_bytes;
    end

    // Quotient rounds up: a part-filled last packet still counts
    ifi_ceil_div u_div (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .start    (div_start),
        .dividend (frame_bytes),
        .divisor  (bytes_per_packet),
        .done     (div_done),
        .quotient (div_quot)
    );

    ifi_period_float u_period (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .load         (per_changed),
        .period_ticks (frame_period_ticks),
        .period_float (period_float)
    );

    // Recompute whenever a setting moves and the packet size is valid; a change mid-divide restarts
    always_comb begin
        st_next      = st_reg;
        pkt_next     = pkt_reg;
        err_fmt_next = err_fmt_comb;
        pend_next    = pend_reg;
        depth_next   = depth_comb;
        filt_next    = FILTER_BASE ^ {area_of_interest_left[0],
                                      area_of_interest_top[0]};
        div_start    = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (cfg_changed || pend_reg) begin
                    pend_next = 1'b0;
                    if (!pkt_static_bad) begin
                        div_start = 1'b1;
                        st_next   = ST_DIVIDE;
                    end
                end
            end
            ST_DIVIDE: begin
                if (cfg_changed) begin
                    pend_next = 1'b1;
                    st_next   = ST_IDLE;
                end else if (div_done) begin
                    pkt_next = div_quot;
                    st_next  = ST_CHECK;
                end
            end
            ST_CHECK: begin
                pend_next    = cfg_changed;
                st_next      = ST_IDLE;
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_reg      <= ST_IDLE;
            pkt_reg     <= RESET_ZERO;
            err_fmt_reg <= 1'b0;
            pend_reg    <= 1'b1;
            depth_reg   <= DEPTH_8;
            filt_reg    <= FILTER_BASE;
        end else begin
            st_reg      <= st_next;
            pkt_reg     <= pkt_next;
            err_fmt_reg <= err_fmt_next;
            pend_reg    <= pend_next;
            depth_reg   <= depth_next;
            filt_reg    <= filt_next;
        end
    end

    // Packet size error: a bad size sets it at once in any state, a finished
    // count decides it otherwise; the set wins over a same-cycle verdict
    always_comb begin
        err_pkt_next = err_pkt_reg;
        if (st_reg == ST_CHECK) begin
            err_pkt_next = (pkt_reg > PKT_MAX_COUNT);
        end
        if ((cfg_changed || (st_reg == ST_IDLE && pend_reg)) && pkt_static_bad) begin
            err_pkt_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            err_pkt_reg <= 1'b0;
        end else begin
            err_pkt_reg <= err_pkt_next;
        end
    end

    // Read mux; fields placed MSB-first, reserved bits zero
    always_comb begin
        rd_word = RESET_ZERO;
        case (reg_addr)
            OFS_PKT_PER_FRAME: rd_word = pkt_reg;
            OFS_POS_STEP:      rd_word = {COL_STEP, ROW_STEP};
            OFS_FRAME_PERIOD:  rd_word = period_float;
            OFS_PIXEL_DEPTH:   rd_word = {depth_reg, 24'h000000};
            OFS_FILTER_ALIGN:  rd_word = {6'h00, filt_reg, 24'h000000};
            OFS_VALIDITY: begin
                rd_word[POS_VALID]      = COLOUR_MODEL;
                rd_word[POS_SETTING1]   = 1'b0;
                rd_word[POS_ERR_FORMAT] = err_fmt_reg;
                rd_word[POS_ERR_PACKET] = err_pkt_reg;
            end
            default: rd_word = RESET_ZERO;
        endcase
    end

    // Writes are acknowledged but never change state
    always_comb begin
        ack_next    = reg_rd || reg_wr;
        rdata_next  = rdata_reg;
        if (reg_rd) begin
            rdata_next = rd_word;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg  <= RESET_ZERO;
            ack_reg    <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            ack_reg    <= ack_next && !unused_wdata ^ unused_wdata;
        end
    end

    // Capture gate: grant or refuse from the error flags at the request edge
    always_comb begin
        cap_next    = capture_req && !err_fmt_reg && !err_pkt_reg;
        refuse_next = capture_req && (err_fmt_reg || err_pkt_reg);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cap_reg    <= 1'b0;
            refuse_reg <= 1'b0;
        end else begin
            cap_reg    <= cap_next;
            refuse_reg <= refuse_next;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign reg_ack         = ack_reg;
    assign capture_start   = cap_reg;
    assign capture_refused = refuse_reg;
    assign format_error    = err_fmt_reg;
    assign packet_error    = err_pkt_reg;
endmodule

// File: ifi_pkg.sv
// Purpose: Constants for the image format inquiry register group
// Assumes: Register bit 0 is the MSB; byte offsets from the mode base
// Notes:   Error and status flags use the MSB-first positions below
package ifi_pkg;
    localparam logic [7:0]  OFS_PKT_PER_FRAME = 8'h48;
    localparam logic [7:0]  OFS_POS_STEP      = 8'h4C;
    localparam logic [7:0]  OFS_FRAME_PERIOD  = 8'h50;
    localparam logic [7:0]  OFS_PIXEL_DEPTH   = 8'h54;
    localparam logic [7:0]  OFS_FILTER_ALIGN  = 8'h58;
    localparam logic [7:0]  OFS_VALIDITY      = 8'h7C;
    // MSB-first bit numbering: bit n sits at position 31-n
    localparam int          POS_VALID         = 31;
    localparam int          POS_SETTING1      = 30;
    localparam int          POS_ERR_FORMAT    = 23;
    localparam int          POS_ERR_PACKET    = 22;
    localparam logic [15:0] COL_STEP          = 16'h0002;
    localparam logic [15:0] ROW_STEP          = 16'h0002;
    localparam logic [7:0]  CC_MONO8          = 8'h00;
    localparam logic [7:0]  CC_YUV422         = 8'h02;
    localparam logic [7:0]  CC_RAW8           = 8'h09;
    localparam logic [7:0]  DEPTH_8           = 8'h08;
    localparam logic [7:0]  DEPTH_16          = 8'h10;
    localparam logic [15:0] SENSOR_WIDTH      = 16'h0500;
    localparam logic [15:0] SENSOR_HEIGHT     = 16'h03C0;
    localparam logic [2:0]  ISO_SPEED_MIN     = 3'h2;
    localparam logic [15:0] PKT_UNIT          = 16'h0004;
    localparam logic [15:0] PKT_MAX_BYTES     = 16'h1000;
    localparam logic [31:0] PKT_MAX_COUNT     = 32'h00000FFF;
    localparam logic [1:0]  FILTER_BASE       = 2'h0;
    localparam logic        COLOUR_MODEL      = 1'b1;
    // Clock period 25 ns as single-float mantissa and power of two
    localparam logic [23:0] TICK_MANT         = 24'hD6BF95;
    localparam logic [7:0]  TICK_EXP_BIAS     = 8'h84;
    localparam logic [31:0] RESET_ZERO        = 32'h00000000;
    typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_CHECK} ifi_state_t;
endpackage

// File: ifi_ceil_div.sv
// Purpose: Sequential ceiling divider for the packet count
// Assumes: Divisor non-zero when start is pulsed
// Notes:   One quotient bit per clock
`timescale 1ns/100ps
module ifi_ceil_div (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             done,
    output logic      [31:0] quotient
);
    import ifi_pkg::*;
    logic [31:0] quot_reg, quot_next;
    logic [32:0] rem_reg, rem_next;
    logic [31:0] num_reg, num_next;
    logic [15:0] den_reg, den_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic        busy_reg, busy_next;
    logic        done_reg, done_next;
    logic [32:0] trial;

    always_comb begin
        quot_next = quot_reg;
        rem_next  = rem_reg;
        num_next  = num_reg;
        den_next  = den_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        trial     = {rem_reg[31:0], num_reg[31]};
        if (start) begin
            num_next  = dividend + {16'h0000, divisor} - 32'h00000001;
            den_next  = divisor;
            rem_next  = 33'h000000000;
            cnt_next  = 6'h20;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            num_next = {num_reg[30:0], 1'b0};
            if (trial >= {17'h00000, den_reg}) begin
                rem_next  = trial - {17'h00000, den_reg};
                quot_next = {quot_reg[30:0], 1'b1};
            end else begin
                rem_next  = trial;
                quot_next = {quot_reg[30:0], 1'b0};
            end
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            quot_reg <= RESET_ZERO;
            rem_reg  <= 33'h000000000;
            num_reg  <= RESET_ZERO;
            den_reg  <= 16'h0000;
            cnt_reg  <= 6'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            quot_reg <= quot_next;
            rem_reg  <= rem_next;
            num_reg  <= num_next;
            den_reg  <= den_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done     = done_reg;
    assign quotient = quot_reg;
endmodule

// File: ifi_period_float.sv
// Purpose: Frame period in clock ticks to single float seconds
// Assumes: Tick is one ref_clk period; mantissa truncated
// Notes:   Result registered one clock after the load pulse
`timescale 1ns/100ps
module ifi_period_float (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        load,
    input  wire logic [31:0] period_ticks,
    output logic      [31:0] period_float
);
    import ifi_pkg::*;
    logic [31:0] val_reg, val_next;
    logic [5:0]  lead;
    logic [31:0] norm;
    logic [47:0] prod;
    logic [7:0]  expo;

    always_comb begin
        lead = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (period_ticks[i]) begin
                lead = 6'(31 - i);
            end
        end
        norm = period_ticks << lead;
        prod = norm[31:8] * TICK_MANT;
        expo = TICK_EXP_BIAS - {2'h0, lead} + {7'h00, prod[47]};
        val_next = val_reg;
        if (load) begin
            if (period_ticks == RESET_ZERO) begin
                val_next = RESET_ZERO;
            end else if (prod[47]) begin
                val_next = {1'b0, expo, prod[46:24]};
            end else begin
                val_next = {1'b0, expo, prod[45:23]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            val_reg <= RESET_ZERO;
        end else begin
            val_reg <= val_next;
        end
    end

    assign period_float = val_reg;
endmodule

// File: ifi_format_inquiry_asserts.sv
// Purpose: Port-level checks of the image format inquiry register group
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/100ps
module ifi_format_inquiry_asserts (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic [2:0]  iso_speed,
    input wire logic [7:0]  color_coding,
    input wire logic [15:0] bytes_per_packet,
    input wire logic        bytes_per_packet_wr,
    input wire logic        capture_req,
    input wire logic        capture_start,
    input wire logic        capture_refused,
    input wire logic        format_error,
    input wire logic        packet_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_ack_follows;
        (reg_rd || reg_wr) |=> reg_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no ack after access");

    property p_ack_cause;
        reg_ack |-> $past(reg_rd || reg_wr);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without access");

    property p_step_read;
        reg_rd && reg_addr == 8'h4C |=> reg_rdata == 32'h00020002;
    endproperty
    a_step_read: assert property (p_step_read) else $error("wrong step word");

    property p_depth_mono;
        reg_rd && reg_addr == 8'h54 && color_coding == 8'h00 && $past(color_coding) == 8'h00
            |=> reg_rdata == 32'h08000000;
    endproperty
    a_depth_mono: assert property (p_depth_mono) else $error("wrong depth word");

    property p_status_word;
        reg_rd && reg_addr == 8'h7C |=> reg_rdata[31:22] == {1'b1, 7'h00, $past(format_error),
            $past(packet_error)} && reg_rdata[21:0] == 22'h000000;
    endproperty
    a_status_word: assert property (p_status_word) else $error("wrong status word");

    property p_unmapped;
        reg_rd && reg_addr == 8'h60 |=> reg_rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_refuse;
        capture_req && (format_error || packet_error) |=> capture_refused && !capture_start;
    endproperty
    a_refuse: assert property (p_refuse) else $error("capture not refused");

    property p_grant;
        capture_req && !format_error && !packet_error |=> capture_start && !capture_refused;
    endproperty
    a_grant: assert property (p_grant) else $error("capture not granted");

    property p_start_clean;
        capture_start |-> $past(!format_error && !packet_error && capture_req);
    endproperty
    a_start_clean: assert property (p_start_clean) else $error("start while in error");

    property p_iso_error;
        iso_speed < 3'h2 |=> format_error;
    endproperty
    a_iso_error: assert property (p_iso_error) else $error("slow bus not flagged");

    property p_pkt_static;
        bytes_per_packet_wr && bytes_per_packet[1:0] != 2'h0 |=> packet_error;
    endproperty
    a_pkt_static: assert property (p_pkt_static) else $error("bad packet size not flagged");

    c_refused: cover property (capture_req && format_error);
    c_granted: cover property (capture_start);
    c_pkt_err: cover property ($rose(packet_error));
endmodule

bind ifi_format_inquiry ifi_format_inquiry_asserts u_ifi_format_inquiry_asserts (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .iso_speed(iso_speed),
    .color_coding(color_coding), .bytes_per_packet(bytes_per_packet),
    .bytes_per_packet_wr(bytes_per_packet_wr), .capture_req(capture_req),
    .capture_start(capture_start), .capture_refused(capture_refused),
    .format_error(format_error), .packet_error(packet_error));

// File: tb_ifi_format_inquiry.sv
// Purpose: Self-checking bench for the image format inquiry registers
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Waits cover the 35-cycle packet count recompute
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_ifi_format_inquiry;
    logic        ref_clk, nrst, reg_rd, reg_wr, reg_ack, bytes_per_packet_wr, capture_req;
    logic [7:0]  reg_addr, color_coding;
    logic [31:0] reg_wdata, reg_rdata, feature_bytes, frame_period_ticks;
    logic [2:0]  iso_speed;
    logic [15:0] area_of_interest_left, area_of_interest_top, bytes_per_packet;
    logic [15:0] area_of_interest_width, area_of_interest_height;
    logic        capture_start, capture_refused, format_error, packet_error;
    int          err_count, checks_done;

    ifi_format_inquiry u_ifi_format_inquiry (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .iso_speed(iso_speed), .area_of_interest_left(area_of_interest_left),
        .area_of_interest_top(area_of_interest_top),
        .area_of_interest_width(area_of_interest_width),
        .area_of_interest_height(area_of_interest_height), .color_coding(color_coding),
        .bytes_per_packet(bytes_per_packet), .bytes_per_packet_wr(bytes_per_packet_wr),
        .feature_bytes(feature_bytes), .frame_period_ticks(frame_period_ticks),
        .capture_req(capture_req), .capture_start(capture_start),
        .capture_refused(capture_refused), .format_error(format_error),
        .packet_error(packet_error));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        `CHK(reg_ack, 1'b1)
        `CHK(reg_rdata, e)
        // Idle edge so a following read raises the strobe afresh
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        `CHK(reg_ack, 1'b1)
    endtask

    task automatic set_bpp(input logic [15:0] v);
        bytes_per_packet = v;
        bytes_per_packet_wr = 1'b1;
        cyc(1);
        bytes_per_packet_wr = 1'b0;
    endtask

    task automatic cap(input logic s);
        capture_req = 1'b1;
        cyc(1);
        capture_req = 1'b0;
        `CHK(capture_start, s)
        `CHK(capture_refused, ~s)
    endtask

    task automatic restore();
        iso_speed = 3'h3;
        color_coding = 8'h00;
        area_of_interest_left = 16'h0000;
        area_of_interest_top = 16'h0000;
        area_of_interest_width = 16'h0040;
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(4000 * 25);
        err_count++;
        results();
    end

    initial begin
        err_count = 0;
        checks_done = 0;
        nrst = 1'b0;
        {reg_rd, reg_wr, bytes_per_packet_wr, capture_req} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        restore();
        area_of_interest_height = 16'h0030;
        bytes_per_packet = 16'h0400;
        feature_bytes = 32'h00000000;
        frame_period_ticks = 32'h00000001;
        cyc(1);
        `CHK(reg_ack, 1'b0)
        `CHK(reg_rdata, 32'h00000000)
        `CHK(capture_start, 1'b0)
        cyc(2);
        nrst = 1'b1;
        cyc(40);
        rd(8'h48, 32'h00000003);
        feature_bytes = 32'h00000001;
        cyc(40);
        rd(8'h48, 32'h00000004);
        rd(8'h4C, 32'h00020002);
        rd(8'h54, 32'h08000000);
        wr(8'h54, 32'hFFFFFFFF);
        rd(8'h54, 32'h08000000);
        wr(8'h4C, 32'h00000000);
        rd(8'h4C, 32'h00020002);
        rd(8'h60, 32'h00000000);
        color_coding = 8'h02;
        cyc(2);
        rd(8'h54, 32'h10000000);
        color_coding = 8'h09;
        cyc(2);
        rd(8'h54, 32'h08000000);
        color_coding = 8'h00;
        // Power-of-two tick counts keep the single float exact
        for (int k = 0; k < 4; k++) begin
            frame_period_ticks = 32'h00000001 << (k * 3);
            cyc(2);
            rd(8'h50, {1'b0, 8'h65 + 8'(k * 3), 23'h56BF95});
        end
        for (int i = 0; i < 4; i++) begin
            area_of_interest_left = {15'h0000, i[1]};
            area_of_interest_top = {15'h0000, i[0]};
            cyc(2);
            rd(8'h58, {8'(i), 24'h000000});
            rd(8'h7C, (i == 0) ? 32'h80000000 : 32'h80800000);
        end
        restore();
        cyc(40);
        cap(1'b1);
        for (int i = 0; i < 3; i++) begin
            case (i)
                0: iso_speed = 3'h1;
                1: color_coding = 8'h05;
                default: begin
                    area_of_interest_left = 16'h0002;
                    area_of_interest_width = 16'h0500;
                end
            endcase
            cyc(2);
            `CHK(format_error, 1'b1)
            rd(8'h7C, 32'h80800000);
            cap(1'b0);
            restore();
            cyc(40);
            `CHK(format_error, 1'b0)
        end
        set_bpp(16'h0006);
        cyc(1);
        `CHK(packet_error, 1'b1)
        rd(8'h7C, 32'h80400000);
        cap(1'b0);
        set_bpp(16'h0400);
        cyc(40);
        `CHK(packet_error, 1'b0)
        area_of_interest_width = 16'h0500;
        area_of_interest_height = 16'h03C0;
        feature_bytes = 32'h00000000;
        set_bpp(16'h0004);
        cyc(40);
        rd(8'h48, 32'h0004B000);
        `CHK(packet_error, 1'b1)
        cap(1'b0);
        set_bpp(16'h0400);
        cyc(40);
        rd(8'h48, 32'h000004B0);
        `CHK(packet_error, 1'b0)
        cap(1'b1);
        results();
    end
endmodule
